// ==== hdl/tocp_map.svh ====
`ifndef TOCP_MAP_SVH
`define TOCP_MAP_SVH

// APB byte addresses
`define TOCP_CTRL1_ADDR 8'h00
`define TOCP_CTRL2_ADDR 8'h04
`define TOCP_STATUS_ADDR 8'h08
`define TOCP_OC1H_ADDR 8'h0C
`define TOCP_OC1L_ADDR 8'h10
`define TOCP_OC2H_ADDR 8'h14
`define TOCP_OC2L_ADDR 8'h18
`define TOCP_IC1H_ADDR 8'h1C
`define TOCP_IC1L_ADDR 8'h20
`define TOCP_IC2H_ADDR 8'h24
`define TOCP_IC2L_ADDR 8'h28
`define TOCP_CNTH_ADDR 8'h2C
`define TOCP_CNTL_ADDR 8'h30

// Control one fields
`define TOCP_C1_LVL1 0
`define TOCP_C1_LVL2 1
`define TOCP_C1_EDGE1 2
`define TOCP_C1_FORCE1 3
`define TOCP_C1_FORCE2 4
`define TOCP_C1_COMPARE_IRQ_ENABLE 5
`define TOCP_C1_CAPTURE_IRQ_ENABLE 6
`define TOCP_C1_EDGE2 7

// Control two fields
`define TOCP_C2_OC1E 0
`define TOCP_C2_OC2E 1
`define TOCP_C2_OPM 2
`define TOCP_C2_PWM 3
`define TOCP_C2_CS_LO 4
`define TOCP_C2_CS_HI 5
`define TOCP_C2_EXTEDGE 6

// Status fields
`define TOCP_SR_OCF1 0
`define TOCP_SR_OCF2 1
`define TOCP_SR_CAPTURE_FLAG_ONE 2
`define TOCP_SR_CAPTURE_FLAG_TWO 3

// Clock select codes and prescaler masks
`define TOCP_CS_DIV4 2'h0
`define TOCP_CS_DIV8 2'h1
`define TOCP_CS_DIV2 2'h2
`define TOCP_CS_EXT 2'h3
`define TOCP_MASK_DIV2 3'h1
`define TOCP_MASK_DIV4 3'h3
`define TOCP_MASK_DIV8 3'h7

// Reset and reload values
`define TOCP_OCR_RST 16'h8000
`define TOCP_CNT_RST 16'hFFFC
`define TOCP_OPM_CAPT 16'hFFFD
`define TOCP_CTRL_RST 8'h00

`endif

// ==== hdl/tocp_pkg.sv ====
package tocp_pkg;

  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] sync;
  } tocp_sync_s;

  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [15:0] cnt;
    logic [2:0] div;
    logic cnt_new;
    logic [15:0] ocr1;
    logic [15:0] ocr2;
    logic [7:0] hi1;
    logic [7:0] hi2;
    logic inh1;
    logic inh2;
    logic [15:0] icr1;
    logic [15:0] icr2;
    logic lock1;
    logic lock2;
    logic [3:0] flags;
    logic [3:0] armed;
    logic [2:0] pin_prev;
    logic out1;
    logic out2;
    logic oe1_b;
    logic oe2_b;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tocp_state_s;

endpackage

// ==== hdl/tocp_sync.sv ====
`timescale 1ns/1ps
module tocp_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Pins in, synchronised out
  input wire logic [2:0] d,
  output logic [2:0] q
);

  tocp_pkg::tocp_sync_s st;
  tocp_pkg::tocp_sync_s nxt;

  always_comb begin
    nxt = st;
    nxt.meta = d;
    nxt.sync = st.meta;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= nxt;
    end
  end

  assign q = st.sync;

endmodule // tocp_sync

// ==== hdl/tocp_top.sv ====
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "tocp_map.svh"

// How it works
// - Match sets flag, drives pin, requests interrupt
// - Two 16-bit compares checked every timer tick
// - Compare values software-owned, reset to 8000h
// - Output disabled: pin stays general I/O
// - Compare pin latches low during reset
// - Interrupt needs enable and clear global mask
// - Timer clock CPU/2, /4, /8 or external
// - Flag clear: status read, then low byte
// - High byte write inhibits compare until low
// - Flag and pin update in matching count
// - Force copies level, no flag, no interrupt
// - Force ignored in one-pulse or PWM mode
// - One-pulse bit uses capture one, compare one
// - Trigger: counter FFFCh, pulse level, capture FFFDh
// - Compare one match ends pulse level
// - Trigger capture flag requests enabled interrupt
// - Capture clear: status read, then low byte
// - One-pulse never sets compare flag one
// - PWM wins over one-pulse when both set
// - One-pulse: input one resets, input two captures
// - Pulse lasts compare value plus four counts
// - Both select bits one picks external clock
module tocp_top (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // CPU interrupt mask and request
  input wire logic GLOBAL_IRQ_MASK,
  output logic TIMER_IRQ,
  // Timer pins
  input wire logic EXT_TIMER_CLK,
  input wire logic CAPTURE_IN_ONE,
  input wire logic CAPTURE_IN_TWO,
  output logic CMP_OUT_ONE,
  output logic CMP_OE_ONE_B,
  output logic CMP_OUT_TWO,
  output logic CMP_OE_TWO_B
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  localparam tocp_pkg::tocp_state_s RST_STATE = '{
    ocr1: `TOCP_OCR_RST,
    ocr2: `TOCP_OCR_RST,
    cnt: `TOCP_CNT_RST,
    oe1_b: 1'b1,
    oe2_b: 1'b1,
    default: '0
  };

  tocp_pkg::tocp_state_s st;
  tocp_pkg::tocp_state_s nxt;

  logic [2:0] sync_q;
  logic [2:0] rise;
  logic [2:0] fall;
  logic acc_done;
  logic wr_en;
  logic rd_en;
  logic pwm_act;
  logic opm_act;
  logic [1:0] clk_sel;
  logic [2:0] div_mask;
  logic int_tick;
  logic ext_edge;
  logic tick;
  logic cap1_edge;
  logic cap2_edge;
  logic opm_trig;
  logic match1;
  logic match2;
  logic lo1_acc;
  logic lo2_acc;
  logic ic1l_acc;
  logic ic2l_acc;
  logic force1;
  logic force2;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  tocp_sync u_sync (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .d({CAPTURE_IN_TWO, CAPTURE_IN_ONE, EXT_TIMER_CLK}),
    .q(sync_q)
  );

  assign rise = sync_q & ~st.pin_prev;
  assign fall = ~sync_q & st.pin_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and timing
  assign acc_done = PSEL & PENABLE & st.pready;
  assign wr_en = acc_done & PWRITE;
  assign rd_en = acc_done & ~PWRITE;
  assign pwm_act = st.ctrl2[`TOCP_C2_PWM];
  assign opm_act = st.ctrl2[`TOCP_C2_OPM] & ~pwm_act;
  assign clk_sel = st.ctrl2[`TOCP_C2_CS_HI:`TOCP_C2_CS_LO];
  assign div_mask = (clk_sel == `TOCP_CS_DIV2) ? `TOCP_MASK_DIV2 :
                    (clk_sel == `TOCP_CS_DIV4) ? `TOCP_MASK_DIV4 :
                    `TOCP_MASK_DIV8;
  assign int_tick = (st.div & div_mask) == div_mask;
  assign ext_edge = st.ctrl2[`TOCP_C2_EXTEDGE] ? rise[0] : fall[0];
  assign tick = (clk_sel == `TOCP_CS_EXT) ? ext_edge : int_tick;
  assign cap1_edge = st.ctrl1[`TOCP_C1_EDGE1] ? rise[1] : fall[1];
  assign cap2_edge = st.ctrl1[`TOCP_C1_EDGE2] ? rise[2] : fall[2];
  assign opm_trig = opm_act & cap1_edge;
  // Compare once per new count value
  assign match1 = st.cnt_new & (st.cnt == st.ocr1) & ~st.inh1;
  assign match2 = st.cnt_new & (st.cnt == st.ocr2) & ~st.inh2;
  assign lo1_acc = acc_done & (PADDR == `TOCP_OC1L_ADDR);
  assign lo2_acc = acc_done & (PADDR == `TOCP_OC2L_ADDR);
  assign ic1l_acc = acc_done & (PADDR == `TOCP_IC1L_ADDR);
  assign ic2l_acc = acc_done & (PADDR == `TOCP_IC2L_ADDR);
  assign force1 = wr_en & (PADDR == `TOCP_CTRL1_ADDR)
                & PWDATA[`TOCP_C1_FORCE1] & ~opm_act & ~pwm_act;
  assign force2 = wr_en & (PADDR == `TOCP_CTRL1_ADDR)
                & PWDATA[`TOCP_C1_FORCE2] & ~opm_act & ~pwm_act;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt = st;
    nxt.pin_prev = sync_q;
    nxt.div = st.div + 3'h1;
    nxt.pready = PSEL & ~PENABLE;
    nxt.pslverr = 1'b0;
    // Bus setup: read mux and error
    if (PSEL && !PENABLE) begin
      nxt.prdata = 32'h0;
      if (PADDR == `TOCP_CTRL1_ADDR) begin
        nxt.prdata[7:0] = st.ctrl1 & 8'hE7;
      end else if (PADDR == `TOCP_CTRL2_ADDR) begin
        nxt.prdata[7:0] = st.ctrl2;
      end else if (PADDR == `TOCP_STATUS_ADDR) begin
        nxt.prdata[3:0] = st.flags;
      end else if (PADDR == `TOCP_OC1H_ADDR) begin
        nxt.prdata[7:0] = st.ocr1[15:8];
      end else if (PADDR == `TOCP_OC1L_ADDR) begin
        nxt.prdata[7:0] = st.ocr1[7:0];
      end else if (PADDR == `TOCP_OC2H_ADDR) begin
        nxt.prdata[7:0] = st.ocr2[15:8];
      end else if (PADDR == `TOCP_OC2L_ADDR) begin
        nxt.prdata[7:0] = st.ocr2[7:0];
      end else if (PADDR == `TOCP_IC1H_ADDR) begin
        nxt.prdata[7:0] = st.icr1[15:8];
      end else if (PADDR == `TOCP_IC1L_ADDR) begin
        nxt.prdata[7:0] = st.icr1[7:0];
      end else if (PADDR == `TOCP_IC2H_ADDR) begin
        nxt.prdata[7:0] = st.icr2[15:8];
      end else if (PADDR == `TOCP_IC2L_ADDR) begin
        nxt.prdata[7:0] = st.icr2[7:0];
      end else if (PADDR == `TOCP_CNTH_ADDR) begin
        nxt.prdata[7:0] = st.cnt[15:8];
      end else if (PADDR == `TOCP_CNTL_ADDR) begin
        nxt.prdata[7:0] = st.cnt[7:0];
      end else begin
        nxt.pslverr = 1'b1;
      end
    end
    // Register writes
    if (wr_en) begin
      if (PADDR == `TOCP_CTRL1_ADDR) begin
        nxt.ctrl1 = PWDATA[7:0];
      end else if (PADDR == `TOCP_CTRL2_ADDR) begin
        nxt.ctrl2 = PWDATA[7:0];
      end else if (PADDR == `TOCP_OC1H_ADDR) begin
        nxt.hi1 = PWDATA[7:0];
        nxt.inh1 = 1'b1;
      end else if (PADDR == `TOCP_OC1L_ADDR) begin
        nxt.ocr1 = {st.inh1 ? st.hi1 : st.ocr1[15:8], PWDATA[7:0]};
        nxt.inh1 = 1'b0;
      end else if (PADDR == `TOCP_OC2H_ADDR) begin
        nxt.hi2 = PWDATA[7:0];
        nxt.inh2 = 1'b1;
      end else if (PADDR == `TOCP_OC2L_ADDR) begin
        nxt.ocr2 = {st.inh2 ? st.hi2 : st.ocr2[15:8], PWDATA[7:0]};
        nxt.inh2 = 1'b0;
      end
    end
    nxt.oe1_b = ~nxt.ctrl2[`TOCP_C2_OC1E];
    nxt.oe2_b = ~nxt.ctrl2[`TOCP_C2_OC2E];
    // Capture read-out lock
    if (rd_en && PADDR == `TOCP_IC1H_ADDR) begin
      nxt.lock1 = 1'b1;
    end else if (ic1l_acc && !PWRITE) begin
      nxt.lock1 = 1'b0;
    end
    if (rd_en && PADDR == `TOCP_IC2H_ADDR) begin
      nxt.lock2 = 1'b1;
    end else if (ic2l_acc && !PWRITE) begin
      nxt.lock2 = 1'b0;
    end
    // Counter and reload
    nxt.cnt_new = tick | opm_trig | (pwm_act & match2);
    if (opm_trig || (pwm_act && match2)) begin
      nxt.cnt = `TOCP_CNT_RST;
    end else if (tick) begin
      nxt.cnt = st.cnt + 16'h0001;
    end
    // Flag clear by two steps
    if (rd_en && PADDR == `TOCP_STATUS_ADDR) begin
      nxt.armed = st.prdata[3:0] & st.flags;
    end
    if (lo1_acc && st.armed[`TOCP_SR_OCF1]) begin
      nxt.flags[`TOCP_SR_OCF1] = 1'b0;
      nxt.armed[`TOCP_SR_OCF1] = 1'b0;
    end
    if (lo2_acc && st.armed[`TOCP_SR_OCF2]) begin
      nxt.flags[`TOCP_SR_OCF2] = 1'b0;
      nxt.armed[`TOCP_SR_OCF2] = 1'b0;
    end
    if (ic1l_acc && st.armed[`TOCP_SR_CAPTURE_FLAG_ONE]) begin
      nxt.flags[`TOCP_SR_CAPTURE_FLAG_ONE] = 1'b0;
      nxt.armed[`TOCP_SR_CAPTURE_FLAG_ONE] = 1'b0;
    end
    if (ic2l_acc && st.armed[`TOCP_SR_CAPTURE_FLAG_TWO]) begin
      nxt.flags[`TOCP_SR_CAPTURE_FLAG_TWO] = 1'b0;
      nxt.armed[`TOCP_SR_CAPTURE_FLAG_TWO] = 1'b0;
    end
    // Flag set wins over clear
    if (match1 && !opm_act && !pwm_act) begin
      nxt.flags[`TOCP_SR_OCF1] = 1'b1;
    end
    if (match2 && !pwm_act) begin
      nxt.flags[`TOCP_SR_OCF2] = 1'b1;
    end
    // Captures
    if (opm_trig) begin
      nxt.icr1 = `TOCP_OPM_CAPT;
      nxt.flags[`TOCP_SR_CAPTURE_FLAG_ONE] = 1'b1;
    end else if (pwm_act && match2) begin
      nxt.flags[`TOCP_SR_CAPTURE_FLAG_ONE] = 1'b1;
    end else if (cap1_edge && !opm_act && !pwm_act && !st.lock1) begin
      nxt.icr1 = st.cnt;
      nxt.flags[`TOCP_SR_CAPTURE_FLAG_ONE] = 1'b1;
    end
    if (cap2_edge && !st.lock2) begin
      nxt.icr2 = st.cnt;
      nxt.flags[`TOCP_SR_CAPTURE_FLAG_TWO] = 1'b1;
    end
    // Output pin latches
    if (pwm_act) begin
      if (match2) begin
        nxt.out1 = st.ctrl1[`TOCP_C1_LVL2];
      end else if (match1) begin
        nxt.out1 = st.ctrl1[`TOCP_C1_LVL1];
      end
    end else if (opm_act) begin
      if (opm_trig) begin
        nxt.out1 = st.ctrl1[`TOCP_C1_LVL2];
      end else if (match1) begin
        nxt.out1 = st.ctrl1[`TOCP_C1_LVL1];
      end
    end else begin
      if (force1 && !st.oe1_b) begin
        nxt.out1 = PWDATA[`TOCP_C1_LVL1];
      end else if (match1 && !st.oe1_b) begin
        nxt.out1 = st.ctrl1[`TOCP_C1_LVL1];
      end
      if (force2 && !st.oe2_b) begin
        nxt.out2 = PWDATA[`TOCP_C1_LVL2];
      end else if (match2 && !st.oe2_b) begin
        nxt.out2 = st.ctrl1[`TOCP_C1_LVL2];
      end
    end
    // Interrupt request
    nxt.irq = ~GLOBAL_IRQ_MASK & (
      (st.ctrl1[`TOCP_C1_COMPARE_IRQ_ENABLE] &
       (st.flags[`TOCP_SR_OCF1] | st.flags[`TOCP_SR_OCF2])) |
      (st.ctrl1[`TOCP_C1_CAPTURE_IRQ_ENABLE] &
       (st.flags[`TOCP_SR_CAPTURE_FLAG_ONE] | st.flags[`TOCP_SR_CAPTURE_FLAG_TWO])));
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st <= RST_STATE;
    end else begin
      st <= nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign PRDATA = st.prdata;
  assign PREADY = st.pready;
  assign PSLVERR = st.pslverr;
  assign TIMER_IRQ = st.irq;
  assign CMP_OUT_ONE = st.out1;
  assign CMP_OUT_TWO = st.out2;
  assign CMP_OE_ONE_B = st.oe1_b;
  assign CMP_OE_TWO_B = st.oe2_b;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  AST_MATCH_FLAG: assert property (
    match1 && !opm_act && !pwm_act |=> st.flags[`TOCP_SR_OCF1])
    else $error("compare one match did not set its flag");

  AST_PIN_LEVEL: assert property (
    match1 && !opm_act && !pwm_act && !force1 && !st.oe1_b
    |=> CMP_OUT_ONE == $past(st.ctrl1[`TOCP_C1_LVL1]))
    else $error("compare pin did not take programmed level");

  AST_OCR_HOLD: assert property (
    !(wr_en && PADDR == `TOCP_OC1L_ADDR) |=> $stable(st.ocr1))
    else $error("compare value changed without a low byte write");

  AST_INHIBIT: assert property (
    wr_en && PADDR == `TOCP_OC2H_ADDR
    |=> st.inh2 && !match2)
    else $error("compare two not inhibited after high byte write");

  AST_IRQ_MASK: assert property (
    GLOBAL_IRQ_MASK |=> !TIMER_IRQ)
    else $error("interrupt raised while globally masked");

  AST_OPM_TRIG: assert property (
    opm_trig |=> st.cnt == `TOCP_CNT_RST && st.icr1 == `TOCP_OPM_CAPT
      && st.flags[`TOCP_SR_CAPTURE_FLAG_ONE]
      && CMP_OUT_ONE == $past(st.ctrl1[`TOCP_C1_LVL2]))
    else $error("one-pulse trigger effects missing");

  AST_OPM_NO_OCF1: assert property (
    opm_act && !st.flags[`TOCP_SR_OCF1] |=> !st.flags[`TOCP_SR_OCF1])
    else $error("compare flag one set in one-pulse mode");

  AST_FORCE: assert property (
    force1 && !st.oe1_b && !st.flags[`TOCP_SR_OCF1] && !match1
    |=> CMP_OUT_ONE == $past(PWDATA[`TOCP_C1_LVL1])
      && !st.flags[`TOCP_SR_OCF1])
    else $error("forced level wrong or flag set");

  AST_CLEAR: assert property (
    lo2_acc && st.armed[`TOCP_SR_OCF2] && !match2
    |=> !st.flags[`TOCP_SR_OCF2])
    else $error("armed compare flag two not cleared by low byte");

  AST_HOLD_FLAG: assert property (
    st.flags[`TOCP_SR_OCF2] && !st.armed[`TOCP_SR_OCF2]
    |=> st.flags[`TOCP_SR_OCF2])
    else $error("compare flag two cleared without status read");

  AST_TICK_DIV2: assert property (
    clk_sel == `TOCP_CS_DIV2 && tick ##1 clk_sel == `TOCP_CS_DIV2
    |-> !tick ##1 (tick || clk_sel != `TOCP_CS_DIV2))
    else $error("divide by two tick spacing wrong");

  COV_OPM_TRIG: cover property (opm_trig ##[1:300] match1);
  COV_OCF1: cover property (match1 && !opm_act && !pwm_act);
  COV_FORCE: cover property (force1 && !st.oe1_b);
  COV_CLEAR: cover property (lo1_acc && st.armed[`TOCP_SR_OCF1]);

endmodule // tocp_top

// ==== dv/tocp_pins.sv ====
`timescale 1ns/1ps
module tocp_pins (
  // Clock
  input wire logic clk,
  // Pins toward the timer
  output logic ext_clk,
  output logic cap_one,
  output logic cap_two
);
  // Lines idle low
  initial begin
    ext_clk = 1'b0;
    cap_one = 1'b0;
    cap_two = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // Short high pulse on one capture input
  task automatic pulse(input logic one);
    @(posedge clk);
    if (one) begin
      cap_one <= 1'b1;
    end else begin
      cap_two <= 1'b1;
    end
    repeat (2) @(posedge clk);
    cap_one <= 1'b0;
    cap_two <= 1'b0;
  endtask
  // Burst of edges, ten core cycles apart, still after it
  task automatic ext_ticks(input int cnt);
    repeat (cnt) begin
      repeat (5) @(posedge clk);
      ext_clk <= 1'b1;
      repeat (5) @(posedge clk);
      ext_clk <= 1'b0;
    end
  endtask
endmodule // tocp_pins

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`include "tocp_map.svh"
module testbench;
  logic clk;
  logic rst_b;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic gmask;
  logic irq;
  logic ext_clk;
  logic cap_one;
  logic cap_two;
  logic out1;
  logic oe1_b;
  logic out2;
  logic oe2_b;
  logic last_err;
  logic [7:0] d;
  logic [15:0] c;
  logic [15:0] t;
  int err_total = 0;
  int n_checks = 0;
  int n;
  localparam logic [16:0] ROWS [15] = '{
    17'h00000, 17'h00400, 17'h00800, 17'h00C80, 17'h01000, 17'h01480,
    17'h01800, 17'h10C12, 17'h11034, 17'h114AB, 17'h118CD, 17'h00C12,
    17'h01034, 17'h014AB, 17'h018CD};
  localparam logic [1:0] CSEL [3] = '{`TOCP_CS_DIV2, `TOCP_CS_DIV4,
    `TOCP_CS_DIV8};
  localparam int DV [3] = '{2, 4, 8};

  tocp_top i_tocp_top (
    .CORE_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .GLOBAL_IRQ_MASK(gmask),
    .TIMER_IRQ(irq), .EXT_TIMER_CLK(ext_clk), .CAPTURE_IN_ONE(cap_one),
    .CAPTURE_IN_TWO(cap_two), .CMP_OUT_ONE(out1), .CMP_OE_ONE_B(oe1_b),
    .CMP_OUT_TWO(out2), .CMP_OE_TWO_B(oe2_b));
  tocp_pins i_tocp_pins (.clk(clk), .ext_clk(ext_clk),
    .cap_one(cap_one), .cap_two(cap_two));

  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic okchk(input logic ok);
    chk({7'h00, ok}, 8'h01);
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [7:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    okchk(k < 20);
    d = prdata[7:0];
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    apb(1'b1, a, v);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 8'h00);
  endtask
  task automatic cnt_rd();
    rd(`TOCP_CNTH_ADDR);
    c[15:8] = d;
    rd(`TOCP_CNTL_ADDR);
    c[7:0] = d;
  endtask
  task automatic wait_out1(input logic v, input int lim);
    n = 0;
    while (out1 !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #200000;
    err_total++;
    complete_run();
  end
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    gmask = 1'b0;
    repeat (6) @(posedge clk);
    chk({4'h0, out1, out2, oe1_b, oe2_b}, 8'h03);
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 15; i++) begin
      if (ROWS[i][16]) begin
        wr(ROWS[i][15:8], ROWS[i][7:0]);
      end else begin
        rd(ROWS[i][15:8]);
        chk(d, ROWS[i][7:0]);
      end
    end
    rd(8'h3C);
    okchk(last_err);
    // Prescaler and external clock
    for (int i = 0; i < 3; i++) begin
      wr(`TOCP_CTRL2_ADDR, {2'h0, CSEL[i], 4'h0});
      rd(`TOCP_CNTL_ADDR);
      c[7:0] = d;
      repeat (64) @(posedge clk);
      rd(`TOCP_CNTL_ADDR);
      t[7:0] = d - c[7:0];
      n = 67 / DV[i] - t[7:0];
      okchk(n >= -1 && n <= 1);
    end
    wr(`TOCP_CTRL2_ADDR, 8'h70);
    rd(`TOCP_CNTL_ADDR);
    c[7:0] = d;
    i_tocp_pins.ext_ticks(8);
    repeat (6) @(posedge clk);
    rd(`TOCP_CNTL_ADDR);
    chk(d - c[7:0], 8'h08);
    // Match on channel one, flag clear
    wr(`TOCP_CTRL2_ADDR, 8'h21);
    cnt_rd();
    t = c + 16'h0040;
    wr(`TOCP_OC1H_ADDR, t[15:8]);
    wr(`TOCP_OC1L_ADDR, t[7:0]);
    wr(`TOCP_CTRL1_ADDR, 8'h21);
    chk({7'h00, oe1_b}, 8'h00);
    wait_out1(1'b1, 300);
    okchk(n < 300);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h01);
    rd(`TOCP_STATUS_ADDR);
    chk(d & 8'h03, 8'h01);
    rd(`TOCP_OC1H_ADDR);
    rd(`TOCP_STATUS_ADDR);
    chk(d & 8'h01, 8'h01);
    rd(`TOCP_OC1L_ADDR);
    rd(`TOCP_STATUS_ADDR);
    chk({d[0], irq}, 8'h00);
    // Channel two: inhibit, mask, no output
    gmask <= 1'b1;
    wr(`TOCP_CTRL1_ADDR, 8'h23);
    cnt_rd();
    t = c + 16'h0040;
    wr(`TOCP_OC2H_ADDR, t[15:8]);
    wr(`TOCP_OC2L_ADDR, t[7:0]);
    wr(`TOCP_OC2H_ADDR, t[15:8]);
    repeat (200) @(posedge clk);
    rd(`TOCP_STATUS_ADDR);
    chk(d & 8'h02, 8'h00);
    cnt_rd();
    t = c + 16'h0040;
    wr(`TOCP_OC2H_ADDR, t[15:8]);
    wr(`TOCP_OC2L_ADDR, t[7:0]);
    d = 8'h00;
    for (int k = 0; k < 80 && d[1] !== 1'b1; k++) begin
      rd(`TOCP_STATUS_ADDR);
    end
    chk(d & 8'h02, 8'h02);
    chk({6'h00, oe2_b, irq}, 8'h02);
    chk({7'h00, out2}, 8'h00);
    gmask <= 1'b0;
    repeat (3) @(posedge clk);
    chk({7'h00, irq}, 8'h01);
    wr(`TOCP_OC2H_ADDR, t[15:8]);
    rd(`TOCP_STATUS_ADDR);
    wr(`TOCP_OC2L_ADDR, t[7:0]);
    rd(`TOCP_STATUS_ADDR);
    chk(d & 8'h02, 8'h00);
    // Forced levels
    wr(`TOCP_CTRL1_ADDR, 8'h28);
    repeat (2) @(posedge clk);
    chk({7'h00, out1}, 8'h00);
    wr(`TOCP_CTRL1_ADDR, 8'h29);
    repeat (2) @(posedge clk);
    chk({7'h00, out1}, 8'h01);
    rd(`TOCP_STATUS_ADDR);
    chk({6'h00, d[0], irq}, 8'h00);
    wr(`TOCP_CTRL2_ADDR, 8'h25);
    wr(`TOCP_CTRL1_ADDR, 8'h28);
    repeat (2) @(posedge clk);
    chk({7'h00, out1}, 8'h01);
    // Single pulse
    wr(`TOCP_CTRL2_ADDR, 8'h21);
    wr(`TOCP_CTRL1_ADDR, 8'h08);
    wr(`TOCP_OC1H_ADDR, 8'h00);
    wr(`TOCP_OC1L_ADDR, 8'h10);
    wr(`TOCP_CTRL1_ADDR, 8'hC6);
    wr(`TOCP_CTRL2_ADDR, 8'h25);
    i_tocp_pins.pulse(1'b1);
    wait_out1(1'b1, 20);
    okchk(n < 20);
    wait_out1(1'b0, 100);
    okchk(n >= 40 && n <= 44);
    chk({7'h00, irq}, 8'h01);
    rd(`TOCP_STATUS_ADDR);
    chk(d & 8'h05, 8'h04);
    rd(`TOCP_IC1H_ADDR);
    chk(d, 8'hFF);
    rd(`TOCP_IC1L_ADDR);
    chk(d, 8'hFD);
    rd(`TOCP_STATUS_ADDR);
    chk(d & 8'h04, 8'h00);
    i_tocp_pins.pulse(1'b0);
    repeat (6) @(posedge clk);
    rd(`TOCP_STATUS_ADDR);
    chk(d & 8'h08, 8'h08);
    // Both mode bits set: trigger edge ignored
    wr(`TOCP_CTRL2_ADDR, 8'h2D);
    i_tocp_pins.pulse(1'b1);
    repeat (4) @(posedge clk);
    rd(`TOCP_STATUS_ADDR);
    chk({d[2], out1}, 8'h00);
    complete_run();
  end
endmodule // testbench
